// *** sim/dac_chip_model.sv ***
// Purpose: behavioural four-channel serial converter beyond the output port
// Assumes: 16-bit frames msb first, sampled on clock rise while selected
// Notes: held codes move only on the active-low update pulse
module dac_chip_model (
	input wire logic sclk,
	input wire logic sdata,
	input wire logic cs_n,
	input wire logic ldac_n,
	output dac_port_pkg::dac_frame_t last_frame,
	output logic [7:0] last_bits,
	output dac_port_pkg::dac_code_t held [4]
);
	timeunit 1ns;
	timeprecision 100ps;
	import dac_port_pkg::*;

	dac_frame_t shift_q;
	logic [7:0] bits_q;

	////////////////////////////////////////////////////////////////////////////////
	// outputs wake at mid-scale, like the real part
	initial begin
		shift_q = 16'h0000;
		bits_q = 8'h00;
		last_frame = 16'h0000;
		last_bits = 8'h00;
		foreach (held[i]) held[i] = 12'h800;
	end

	// edges outside a frame are ignored, so a stray clock cannot corrupt data
	always @(posedge sclk) begin
		if (!cs_n) begin
			shift_q <= {shift_q[14:0], sdata};
			bits_q <= bits_q + 8'h01;
		end
	end
	always @(negedge cs_n) bits_q <= 8'h00;

	// frame closes when select is released
	always @(posedge cs_n) begin
		last_frame <= shift_q;
		last_bits <= bits_q;
	end

	// one channel per pulse; no simultaneous update exists
	always @(negedge ldac_n) begin
		held[last_frame[15:14]] <= last_frame[11:0];
	end
endmodule

// *** sim/test_dac_write_update_port.sv ***
// Purpose: self-checking bench for the analog output register port
// Assumes: strobes are driven 1 ns after the rising edge
// Notes: every access takes two cycles so no strobe is set twice in one step
module test_dac_write_update_port;
	timeunit 1ns;
	timeprecision 100ps;
	import dac_port_pkg::*;

	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] bus_addr = 4'h0;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	port_byte_t bus_wdata = 8'h00;
	port_byte_t bus_rdata;
	logic range_bipolar = 1'b0;
	logic dac_range_bipolar, dac_sclk, dac_sdata, dac_cs_n, dac_ldac_n, dac_shift_pending;
	dac_code_t dut_code [4];
	dac_code_t held [4];
	dac_code_t exp_code [4];
	dac_frame_t frame;
	logic [7:0] bits;
	int errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int pend_cyc = 0;
	port_byte_t d;

	always #10 ref_clk = ~ref_clk;

	dac_write_update_port DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .range_bipolar(range_bipolar),
		.dac_range_bipolar(dac_range_bipolar), .dac_sclk(dac_sclk), .dac_sdata(dac_sdata), .dac_cs_n(dac_cs_n),
		.dac_ldac_n(dac_ldac_n), .dac_shift_pending(dac_shift_pending), .ch_code0(dut_code[0]),
		.ch_code1(dut_code[1]), .ch_code2(dut_code[2]), .ch_code3(dut_code[3]));

	dac_chip_model conv (.sclk(dac_sclk), .sdata(dac_sdata), .cs_n(dac_cs_n), .ldac_n(dac_ldac_n),
		.last_frame(frame), .last_bits(bits), .held(held));

	////////////////////////////////////////////////////////////////////////////////
	// pending length is counted here, independent of the polling rate
	always @(posedge ref_clk) begin
		if (dac_shift_pending === 1'b1) pend_cyc++;
		cycles++;
		if (cycles == 10000) begin
			errors++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask

	// strobe up one edge, down the next; returns just after the taking edge
	task automatic wr(input logic [3:0] a, input port_byte_t v);
		@(posedge ref_clk);
		#1;
		bus_addr = a;
		bus_wdata = v;
		bus_wr = 1'b1;
		@(posedge ref_clk);
		#1;
		bus_wr = 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output port_byte_t v);
		@(posedge ref_clk);
		#1;
		bus_addr = a;
		bus_rd = 1'b1;
		@(posedge ref_clk);
		#1;
		bus_rd = 1'b0;
		v = bus_rdata;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// one full load: write, refused early update, poll, update, compare all channels
	task automatic load(input dac_chan_t ch, input dac_code_t code, input logic [1:0] pad);
		port_byte_t v;
		int n;
		pend_cyc = 0;
		wr(4'h4, code[7:0]);
		wr(4'h5, {ch, pad, code[11:8]});
		check("pending after write", 16'h1, dac_shift_pending);
		rd(4'h5, v);
		check("update while pending", 16'h1, dac_ldac_n);
		check("code while pending", exp_code[ch], dut_code[ch]);
		rd(4'h4, v);
		check("status busy", 16'h80, v);
		n = 0;
		while (v[7] !== 1'b0 && n < 400) begin
			rd(4'h4, v);
			n++;
		end
		check("status idle", 16'h00, v);
		check("pending cycles", 16'd500, pend_cyc[15:0]);
		check("frame bits", 16'd16, bits);
		check("frame", {ch, 2'b00, code}, frame);
		exp_code[ch] = code;
		rd(4'h5, v);
		check("update pulse", 16'h0, dac_ldac_n);
		check("update read data", 16'h00, v);
		for (int i = 0; i < 4; i++) begin
			check("channel code", exp_code[i], dut_code[i]);
			check("converter code", exp_code[i], held[i]);
		end
		@(posedge ref_clk);
		#1;
		check("update pulse end", 16'h1, dac_ldac_n);
		$display("test load channel %0d done", ch);
	endtask

	initial begin
		foreach (exp_code[i]) exp_code[i] = 12'h800;
		repeat (16) @(posedge ref_clk);
		#1;
		sys_rst = 1'b0;
		// reset state
		for (int i = 0; i < 4; i++) check("reset code", 16'h800, dut_code[i]);
		check("reset pending", 16'h0, dac_shift_pending);
		check("reset select", 16'h1, dac_cs_n);
		check("reset update", 16'h1, dac_ldac_n);
		check("reset rdata", 16'h00, bus_rdata);
		$display("test reset done");
		// high byte alone must not start a shift
		wr(4'h5, 8'h4F);
		check("lone high write", 16'h0, dac_shift_pending);
		rd(4'h9, d);
		check("unmapped read", 16'h00, d);
		$display("test refusals done");
		// one range for all channels
		range_bipolar = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		check("range bipolar", 16'h1, dac_range_bipolar);
		range_bipolar = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		check("range unipolar", 16'h0, dac_range_bipolar);
		$display("test range done");
		// boundary codes, ignored pad bits set, channels back to back
		load(2'h0, 12'hFFF, 2'b11);
		load(2'h1, 12'hCCD, 2'b00);
		load(2'h2, 12'h000, 2'b00);
		load(2'h3, 12'h6F0, 2'b01);
		print_verdict();
	end
endmodule

// *** verilog/chan_code_reg.sv ***
// Purpose: one output channel's held code, as the converter drives it
// Assumes: load is a one-cycle update pulse shared by all channels
// Notes: resets to mid-scale so the output sits at zero or half scale
`include "dac_port_defs.svh"

module chan_code_reg #(
	parameter logic [1:0] CH = 2'h0
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic load,
	input wire dac_port_pkg::dac_chan_t sel,
	input wire dac_port_pkg::dac_code_t code,
	output dac_port_pkg::dac_code_t code_q
);
	import dac_port_pkg::*;

	dac_code_t code_d;

	// only the channel named by the update takes the new code
	always_comb begin
		code_d = code_q;
		if (load && sel == CH) begin
			code_d = code;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			code_q <= `DAC_CODE_MID;
		end else begin
			code_q <= code_d;
		end
	end

endmodule

// *** verilog/dac_port_defs.svh ***
// Purpose: named offsets, field positions, reset values and timing counts of the output port
// Assumes: included by bare name from every design file that needs it
// Notes: definitions only, no logic
`ifndef DAC_PORT_DEFS_SVH
`define DAC_PORT_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// register offsets on the byte port
`define DAC_OFS_LOW 4'h4
`define DAC_OFS_HIGH 4'h5

// field positions
`define DAC_BUSY_BIT 7
`define DAC_CHAN_MSB 7
`define DAC_CHAN_LSB 6
`define DAC_CODE_HI_MSB 3

// values
`define DAC_CODE_MID 12'h800
`define DAC_CODE_MAX 12'hFFF
`define DAC_BYTE_ZERO 8'h00
`define DAC_STAT_PAD 7'h00
`define DAC_FRAME_PAD 2'h0

////////////////////////////////////////////////////////////////////////////////
// timing: shift-pending time in ns, clock period in ns, counts derived
`define DAC_BUSY_NS 10000
`define DAC_REF_CLK_NS 20
`define DAC_BUSY_CYC (`DAC_BUSY_NS / `DAC_REF_CLK_NS)
`define DAC_FRAME_BITS 16
`define DAC_BIT_CYC (`DAC_BUSY_CYC / `DAC_FRAME_BITS)
`define DAC_HALF_BIT_CYC (`DAC_BIT_CYC / 2)

`endif

// *** verilog/dac_port_pkg.sv ***
// Purpose: shared types of the analog output port
// Assumes: constants live in dac_port_defs.svh
// Notes: serial engine states are Gray coded along idle, shift, hold
package dac_port_pkg;

	typedef logic [11:0] dac_code_t;
	typedef logic [1:0] dac_chan_t;
	typedef logic [7:0] port_byte_t;
	typedef logic [15:0] dac_frame_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SHIFT = 2'b01,
		ST_HOLD = 2'b11
	} shift_state_t;

endpackage

// *** verilog/dac_serial_shift.sv ***
// Purpose: shifts one 16-bit frame into the converter and times the pending flag
// Assumes: start is a one-cycle pulse, ignored while busy
// Notes: frame is channel, two pad bits, 12-bit code, msb first
`include "dac_port_defs.svh"

module dac_serial_shift (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire dac_port_pkg::dac_frame_t frame,
	output logic busy_q,
	output logic sclk_q,
	output logic sdata_q,
	output logic cs_n_q
);
	import dac_port_pkg::*;

	shift_state_t st_q, st_d;
	logic [8:0] tot_q, tot_d;
	logic [4:0] phase_q, phase_d;
	logic [4:0] bits_q, bits_d;
	dac_frame_t sr_q, sr_d;
	logic busy_d, sclk_d, sdata_d, cs_n_d;

	////////////////////////////////////////////////////////////////////////////
	// the flag spans a fixed time, not the shift itself, so hold pads the end
	always_comb begin
		st_d = st_q;
		tot_d = tot_q;
		phase_d = phase_q;
		bits_d = bits_q;
		sr_d = sr_q;
		busy_d = busy_q;
		case (st_q)
			ST_IDLE: begin
				if (start) begin
					st_d = ST_SHIFT;
					sr_d = frame;
					tot_d = 9'h000;
					phase_d = 5'h00;
					bits_d = 5'h00;
					busy_d = 1'b1;
				end
			end
			ST_SHIFT: begin
				tot_d = tot_q + 9'h001;
				if (phase_q == 5'(`DAC_BIT_CYC - 1)) begin
					phase_d = 5'h00;
					sr_d = {sr_q[14:0], 1'b0};
					bits_d = bits_q + 5'h01;
					if (bits_q == 5'(`DAC_FRAME_BITS - 1)) begin
						st_d = ST_HOLD;
					end
				end else begin
					phase_d = phase_q + 5'h01;
				end
			end
			ST_HOLD: begin
				tot_d = tot_q + 9'h001;
				if (tot_q == 9'(`DAC_BUSY_CYC - 1)) begin
					st_d = ST_IDLE;
					busy_d = 1'b0;
				end
			end
			default: begin
				st_d = ST_IDLE;
				busy_d = 1'b0;
			end
		endcase
		// clock high in the second half of each bit, data steady across it
		cs_n_d = (st_d != ST_SHIFT);
		sclk_d = (st_d == ST_SHIFT) && (phase_d >= 5'(`DAC_HALF_BIT_CYC));
		sdata_d = (st_d == ST_SHIFT) && sr_d[15];
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_q <= ST_IDLE;
			tot_q <= 9'h000;
			phase_q <= 5'h00;
			bits_q <= 5'h00;
			sr_q <= 16'h0000;
			busy_q <= 1'b0;
			sclk_q <= 1'b0;
			sdata_q <= 1'b0;
			cs_n_q <= 1'b1;
		end else begin
			st_q <= st_d;
			tot_q <= tot_d;
			phase_q <= phase_d;
			bits_q <= bits_d;
			sr_q <= sr_d;
			busy_q <= busy_d;
			sclk_q <= sclk_d;
			sdata_q <= sdata_d;
			cs_n_q <= cs_n_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// helper counters for the checks below
	logic [9:0] len_q;
	logic [4:0] edges_q;
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !busy_q) begin
			len_q <= 10'h000;
		end else begin
			len_q <= len_q + 10'h001;
		end
		if (sys_rst || (cs_n_q && !$past(cs_n_q))) begin
			edges_q <= 5'h00;
		end else if (sclk_d && !sclk_q) begin
			edges_q <= edges_q + 5'h01;
		end
	end

	a_busy_length: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$fell(busy_q) |-> $past(len_q) == 10'(`DAC_BUSY_CYC - 1))
		else $error("pending flag width is not the shift time");

	a_select_in_busy: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!cs_n_q |-> busy_q)
		else $error("converter selected outside pending time");

	a_frame_clocks: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$rose(cs_n_q) |-> edges_q == 5'(`DAC_FRAME_BITS))
		else $error("frame did not carry sixteen clocks");

endmodule

// *** verilog/dac_write_update_port.sv ***
// Purpose: byte-wide register port that loads four 12-bit output channels through a serial converter
// Assumes: bus strobes and inputs synchronous to ref_clk; one strobe per cycle
// Notes: offset 4 low byte / pending flag, offset 5 channel+high bits / update on read
`include "dac_port_defs.svh"

module dac_write_update_port (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [3:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire dac_port_pkg::port_byte_t bus_wdata,
	output dac_port_pkg::port_byte_t bus_rdata,
	input wire logic range_bipolar,
	output logic dac_range_bipolar,
	output logic dac_sclk,
	output logic dac_sdata,
	output logic dac_cs_n,
	output logic dac_ldac_n,
	output logic dac_shift_pending,
	output dac_port_pkg::dac_code_t ch_code0,
	output dac_port_pkg::dac_code_t ch_code1,
	output dac_port_pkg::dac_code_t ch_code2,
	output dac_port_pkg::dac_code_t ch_code3
);
	import dac_port_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// declarations
	port_byte_t low_q, low_d;
	logic low_seen_q, low_seen_d;
	logic sent_q, sent_d;
	dac_chan_t sent_chan_q, sent_chan_d;
	dac_code_t sent_code_q, sent_code_d;
	port_byte_t rdata_d;
	logic ldac_n_d;
	logic range_d;
	logic upd_d;
	logic start;
	logic busy;
	logic wr_low, wr_high, rd_low, rd_high;
	dac_frame_t frame;

	// strobe decode on the two documented offsets
	always_comb begin
		wr_low = 1'b0;
		wr_high = 1'b0;
		rd_low = 1'b0;
		rd_high = 1'b0;
		if (bus_addr == `DAC_OFS_LOW) begin
			wr_low = bus_wr;
			rd_low = bus_rd;
		end else if (bus_addr == `DAC_OFS_HIGH) begin
			wr_high = bus_wr;
			rd_high = bus_rd;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// data bytes; writes during a shift are dropped so the frame in flight
	// and the code waiting for its update stay consistent
	always_comb begin
		low_d = low_q;
		low_seen_d = low_seen_q;
		start = 1'b0;
		if (wr_low && !busy) begin
			low_d = bus_wdata;
			low_seen_d = 1'b1;
		end
		if (wr_high && !busy && low_seen_q) begin
			low_seen_d = 1'b0;
			start = 1'b1;
		end
	end

	// frame goes out with channel first, then two pad bits, then the code
	assign frame = {bus_wdata[`DAC_CHAN_MSB:`DAC_CHAN_LSB], `DAC_FRAME_PAD,
		bus_wdata[`DAC_CODE_HI_MSB:0], low_q};

	////////////////////////////////////////////////////////////////////////////
	// what was shifted is remembered until its update read arrives
	always_comb begin
		sent_d = sent_q;
		sent_chan_d = sent_chan_q;
		sent_code_d = sent_code_q;
		upd_d = 1'b0;
		if (start) begin
			sent_d = 1'b1;
			sent_chan_d = bus_wdata[`DAC_CHAN_MSB:`DAC_CHAN_LSB];
			sent_code_d = {bus_wdata[`DAC_CODE_HI_MSB:0], low_q};
		end else if (rd_high && !busy && sent_q) begin
			// a read while still shifting is not an update
			sent_d = 1'b0;
			upd_d = 1'b1;
		end
	end

	// each update moves exactly one channel, so no latch of all four at once
	always_comb begin
		ldac_n_d = !upd_d;
	end

	////////////////////////////////////////////////////////////////////////////
	// read data; reserved bits read as zero, offset five reads as zero
	always_comb begin
		rdata_d = `DAC_BYTE_ZERO;
		if (rd_low) begin
			rdata_d = {busy, `DAC_STAT_PAD};
		end else if (rd_high) begin
			rdata_d = `DAC_BYTE_ZERO;
		end
	end

	// one range setting for the converter, not per channel
	always_comb begin
		range_d = range_bipolar;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			low_q <= `DAC_BYTE_ZERO;
			low_seen_q <= 1'b0;
			sent_q <= 1'b0;
			sent_chan_q <= 2'h0;
			sent_code_q <= `DAC_CODE_MID;
			bus_rdata <= `DAC_BYTE_ZERO;
			dac_ldac_n <= 1'b1;
			dac_range_bipolar <= 1'b0;
		end else begin
			low_q <= low_d;
			low_seen_q <= low_seen_d;
			sent_q <= sent_d;
			sent_chan_q <= sent_chan_d;
			sent_code_q <= sent_code_d;
			bus_rdata <= rdata_d;
			dac_ldac_n <= ldac_n_d;
			dac_range_bipolar <= range_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// serial engine
	dac_serial_shift u_shift (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.start(start),
		.frame(frame),
		.busy_q(busy),
		.sclk_q(dac_sclk),
		.sdata_q(dac_sdata),
		.cs_n_q(dac_cs_n)
	);

	assign dac_shift_pending = busy;

	////////////////////////////////////////////////////////////////////////////
	// held codes per channel, loaded in step with the update pulse
	chan_code_reg #(.CH(2'h0)) u_ch0 (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.load(upd_d),
		.sel(sent_chan_q),
		.code(sent_code_q),
		.code_q(ch_code0)
	);

	chan_code_reg #(.CH(2'h1)) u_ch1 (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.load(upd_d),
		.sel(sent_chan_q),
		.code(sent_code_q),
		.code_q(ch_code1)
	);

	chan_code_reg #(.CH(2'h2)) u_ch2 (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.load(upd_d),
		.sel(sent_chan_q),
		.code(sent_code_q),
		.code_q(ch_code2)
	);

	chan_code_reg #(.CH(2'h3)) u_ch3 (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.load(upd_d),
		.sel(sent_chan_q),
		.code(sent_code_q),
		.code_q(ch_code3)
	);

	////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_load_pair;
		rd_high && !busy && sent_q && !start;
	endsequence

	sequence s_update_out;
		!dac_ldac_n ##1 dac_ldac_n;
	endsequence

	a_reset_midscale: assert property (@(posedge ref_clk)
		$past(sys_rst) |-> ch_code0 == `DAC_CODE_MID && ch_code1 == `DAC_CODE_MID
			&& ch_code2 == `DAC_CODE_MID && ch_code3 == `DAC_CODE_MID)
		else $error("channel not at mid-scale after reset");

	a_range_shared: assert property (@(posedge ref_clk) disable iff (sys_rst)
		##1 dac_range_bipolar == $past(range_bipolar))
		else $error("range output does not follow the single setting");

	a_start_pending: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_high && !busy && low_seen_q |=> dac_shift_pending && !dac_cs_n)
		else $error("high byte write did not start the shift");

	a_status_bit: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rd_low |=> bus_rdata == {$past(busy), `DAC_STAT_PAD})
		else $error("status read does not show the pending flag");

	a_update_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_load_pair |=> s_update_out)
		else $error("update read did not give one update pulse");

	a_no_busy_update: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!dac_ldac_n |-> !$past(busy) && $past(rd_high))
		else $error("update pulse without a legal read");

	a_chan_loaded: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(s_load_pair and (sent_chan_q == 2'h1)) |=> ch_code1 == $past(sent_code_q)
			&& ch_code0 == $past(ch_code0) && ch_code2 == $past(ch_code2))
		else $error("update hit the wrong channel or code");

	a_code_fields: assert property (@(posedge ref_clk) disable iff (sys_rst)
		start |=> sent_code_q == {$past(bus_wdata[`DAC_CODE_HI_MSB:0]), $past(low_q)})
		else $error("shifted code is not high nibble and low byte");

	a_low_first: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_low && !busy |=> low_q == $past(bus_wdata) && low_seen_q)
		else $error("low byte not held for the next load");

	// channel zero takes its code on its own update, like channel one
	a_chan_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(s_load_pair and (sent_chan_q == 2'h0)) |=> ch_code0 == $past(sent_code_q))
		else $error("update missed channel zero");

	// a write in the shift window must not disturb the byte in flight
	a_low_kept_busy: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_low && busy |=> low_q == $past(low_q))
		else $error("low byte changed during a shift");

	// half a load is dropped rather than shifting a stale low byte
	a_lone_high: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_high && !busy && !low_seen_q |=> !dac_shift_pending && dac_cs_n)
		else $error("lone high byte started a shift");

	// the converter sees the channel before the code
	a_first_bit: assert property (@(posedge ref_clk) disable iff (sys_rst)
		start |=> dac_sdata == $past(bus_wdata[`DAC_CHAN_MSB]))
		else $error("frame does not open with the channel msb");

	// polling too early must not latch a half-shifted code
	a_busy_read_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rd_high && busy |=> dac_ldac_n)
		else $error("update read honoured while shifting");

	// a second update read repeats nothing
	a_read_no_data: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rd_high && !sent_q |=> dac_ldac_n)
		else $error("update read without shifted data");

	// the update register carries no data back
	a_high_read_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rd_high |=> bus_rdata == `DAC_BYTE_ZERO)
		else $error("offset five read is not zero");

	// idle status reads clear so a poll loop ends
	a_status_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rd_low && !busy |=> bus_rdata == `DAC_BYTE_ZERO)
		else $error("status read not clear when idle");

	// outputs move only with an update pulse
	a_codes_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
		dac_ldac_n |-> $stable(ch_code0) && $stable(ch_code1) && $stable(ch_code2) && $stable(ch_code3))
		else $error("channel code moved without an update pulse");

	// no simultaneous update: at most one channel moves per edge
	a_one_channel: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$onehot0({$changed(ch_code0), $changed(ch_code1), $changed(ch_code2), $changed(ch_code3)}))
		else $error("more than one channel moved at once");

endmodule
